// ---- rtl/ebk_pkg.sv ----
/*
 * Shared constants and types for the embedded block RAM: geometry, register
 * offsets and fields, reset values, memory modes, port widths and bus states.
 * Assumes a single 200 MHz clock and an AXI4-Lite register master.
 */
package ebk_pkg;
    // Storage: 2048 bytes of 8 data bits plus one parity bit
    localparam int EBK_BYTES = 2048;
    localparam int EBK_BYTE_W = 9;
    localparam int EBK_ADDR_W = 14;
    localparam int EBK_DATA_W = 36;
    localparam int EBK_LANES = 4;
    localparam int EBK_AXI_AW = 8;

    // Register byte offsets
    localparam logic [7:0] EBK_CTRL_OFS = 8'h00;
    localparam logic [7:0] EBK_INIT_ADDR_OFS = 8'h04;
    localparam logic [7:0] EBK_INIT_DATA_OFS = 8'h08;
    localparam logic [7:0] EBK_STATUS_OFS = 8'h0C;

    // Control fields
    localparam int EBK_CTRL_RUN_BIT = 0;
    localparam int EBK_CTRL_MODE_LSB = 1;
    localparam int EBK_CTRL_WA_LSB = 3;
    localparam int EBK_CTRL_WB_LSB = 6;
    localparam int EBK_CTRL_OREGA_BIT = 9;
    localparam int EBK_CTRL_OREGB_BIT = 10;
    localparam logic [31:0] EBK_CTRL_RST = 32'h0000_00D8;
    localparam logic [10:0] EBK_INIT_ADDR_RST = 11'h000;

    localparam logic [1:0] EBK_RESP_OKAY = 2'h0;
    localparam logic [1:0] EBK_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        EBK_SP = 2'h0,
        EBK_TDP = 2'h1,
        EBK_PDP = 2'h2
    } ebk_mode_t;

    typedef enum logic [2:0] {
        EBK_W1 = 3'h0,
        EBK_W2 = 3'h1,
        EBK_W4 = 3'h2,
        EBK_W9 = 3'h3,
        EBK_W18 = 3'h4,
        EBK_W36 = 3'h5
    } ebk_width_t;

    typedef enum logic [2:0] {
        EBK_AX_IDLE = 3'b001,
        EBK_AX_ACK = 3'b010,
        EBK_AX_RESP = 3'b100
    } ebk_axst_t;

    // One byte lane of a port access
    typedef struct packed {
        logic on;
        logic [10:0] a;
        logic [8:0] m;
        logic [8:0] d;
    } ebk_lane_t;
endpackage : ebk_pkg

// ---- rtl/ebk_block_ram.sv ----
/*
 * Embedded block RAM with two user ports and an AXI4-Lite control slave.
 * Assumes user logic drives both ports from CLK_SYS and loads the array
 * through the init registers while the run bit is clear.
 */
`timescale 1ns/1ps

module ebk_block_ram
    import ebk_pkg::*;
(
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic RESET_N,
    // Port A
    input wire logic A_EN,
    input wire logic A_WE,
    input wire logic [13:0] A_ADDR,
    input wire logic [35:0] A_WDATA,
    input wire logic [3:0] A_BE,
    output logic [35:0] A_RDATA,
    output logic A_RVALID,
    // Port B
    input wire logic B_EN,
    input wire logic B_WE,
    input wire logic [13:0] B_ADDR,
    input wire logic [35:0] B_WDATA,
    input wire logic [3:0] B_BE,
    output logic [35:0] B_RDATA,
    output logic B_RVALID,
    // AXI4-Lite slave
    input wire logic [7:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [7:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY
);
    logic [8:0] mem_r [0:EBK_BYTES-1];

    logic [31:0] ctrl_r, ctrl_nxt;
    logic [10:0] iaddr_r, iaddr_nxt;
    logic [8:0] idata_r, idata_nxt;
    logic init_we_r, init_we_nxt;
    ebk_axst_t wst_r, wst_nxt, rst_r, rst_nxt;
    logic awready_r, awready_nxt, bvalid_r, bvalid_nxt, arready_r, arready_nxt;
    logic rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] axrdata_r, axrdata_nxt, wmask, status;

    logic run, cfg_err;
    ebk_mode_t mode_eff;
    ebk_width_t eff_w [2];
    logic [1:0] oreg_cfg, in_en, in_we, acc_rd, acc_wr;
    logic [13:0] in_addr [2];
    logic [35:0] in_wd [2];
    logic [3:0] in_be [2];

    logic [1:0] s1_rd_r, s1_rd_nxt, s1_wr_r, s1_wr_nxt, s1_oreg_r, s1_oreg_nxt;
    logic [13:0] s1_addr_r [2], s1_addr_nxt [2];
    logic [35:0] s1_wd_r [2], s1_wd_nxt [2];
    logic [3:0] s1_be_r [2], s1_be_nxt [2];
    ebk_width_t s1_w_r [2], s1_w_nxt [2];
    logic [1:0] p2_vld_r, p2_vld_nxt, rv_r, rv_nxt;
    logic [35:0] p2_d_r [2], p2_d_nxt [2], rd_r [2], rd_nxt [2], rd_now [2];
    ebk_lane_t rl [2];

    // Maps one byte lane of an access onto the byte array, LSB first
    function automatic ebk_lane_t lane_f(input ebk_width_t w, input logic [13:0] a,
                                         input logic [35:0] wd, input logic [3:0] be,
                                         input logic [1:0] i);
        ebk_lane_t l;
        l.on = (i == 2'h0);
        l.a = a[13:3];
        l.m = 9'h001 << a[2:0];
        l.d = 9'(wd[0]) << a[2:0];
        case (w)
            EBK_W2: begin
                l.a = a[12:2];
                l.m = 9'h003 << {a[1:0], 1'b0};
                l.d = 9'(wd[1:0]) << {a[1:0], 1'b0};
            end
            EBK_W4: begin
                l.a = a[11:1];
                l.m = 9'h00F << {a[0], 2'h0};
                l.d = 9'(wd[3:0]) << {a[0], 2'h0};
            end
            EBK_W9: begin
                l.a = a[10:0];
                l.m = 9'h1FF;
                l.d = wd[8:0];
            end
            EBK_W18: begin
                l.on = !i[1] && be[i];
                l.a = {a[9:0], i[0]};
                l.m = 9'h1FF;
                l.d = wd[9*i +: 9];
            end
            EBK_W36: begin
                l.on = be[i];
                l.a = {a[8:0], i};
                l.m = 9'h1FF;
                l.d = wd[9*i +: 9];
            end
            default: ;
        endcase
        return l;
    endfunction : lane_f

    // Configuration decode; illegal codes fall back and raise cfg_err
    always_comb begin
        run = ctrl_r[EBK_CTRL_RUN_BIT];
        mode_eff = ebk_mode_t'(ctrl_r[EBK_CTRL_MODE_LSB +: 2]);
        cfg_err = 1'b0;
        if (ctrl_r[EBK_CTRL_MODE_LSB +: 2] == 2'h3) begin
            mode_eff = EBK_SP;
            cfg_err = 1'b1;
        end
        for (int p = 0; p < 2; p++) begin
            eff_w[p] = ebk_width_t'(ctrl_r[(p == 0 ? EBK_CTRL_WA_LSB : EBK_CTRL_WB_LSB) +: 3]);
            if (eff_w[p] > EBK_W36) begin
                eff_w[p] = EBK_W9;
                cfg_err = 1'b1;
            end
            if (mode_eff == EBK_TDP && eff_w[p] == EBK_W36) begin
                eff_w[p] = EBK_W18;
                cfg_err = 1'b1;
            end
        end
        oreg_cfg = {ctrl_r[EBK_CTRL_OREGB_BIT], ctrl_r[EBK_CTRL_OREGA_BIT]};
    end

    assign in_en = {B_EN, A_EN};
    assign in_we = {B_WE, A_WE};
    assign in_addr = '{A_ADDR, B_ADDR};
    assign in_wd = '{A_WDATA, B_WDATA};
    assign in_be = '{A_BE, B_BE};

    // Port gating, input registers and read pipeline
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            acc_rd[p] = run && in_en[p] && !in_we[p]
                        && (p == 0 ? mode_eff != EBK_PDP : mode_eff != EBK_SP);
            acc_wr[p] = run && in_en[p] && in_we[p]
                        && (p == 0 || mode_eff == EBK_TDP);
            s1_rd_nxt[p] = acc_rd[p];
            s1_wr_nxt[p] = acc_wr[p];
            s1_addr_nxt[p] = in_en[p] ? in_addr[p] : s1_addr_r[p];
            s1_wd_nxt[p] = in_en[p] ? in_wd[p] : s1_wd_r[p];
            s1_be_nxt[p] = (eff_w[p] >= EBK_W18) ? in_be[p] : 4'hF;
            s1_w_nxt[p] = eff_w[p];
            s1_oreg_nxt[p] = oreg_cfg[p];
            // Narrow reads go through a named lane, not a select on a call result
            rl[p] = lane_f(s1_w_r[p], s1_addr_r[p], '0, '0, 2'h0);
            rd_now[p] = '0;
            case (s1_w_r[p])
                EBK_W9: rd_now[p] = 36'(mem_r[s1_addr_r[p][10:0]]);
                EBK_W18: rd_now[p] = 36'({mem_r[{s1_addr_r[p][9:0], 1'b1}],
                                          mem_r[{s1_addr_r[p][9:0], 1'b0}]});
                EBK_W36: rd_now[p] = {mem_r[{s1_addr_r[p][8:0], 2'h3}],
                                      mem_r[{s1_addr_r[p][8:0], 2'h2}],
                                      mem_r[{s1_addr_r[p][8:0], 2'h1}],
                                      mem_r[{s1_addr_r[p][8:0], 2'h0}]};
                default: rd_now[p] = 36'(
                    (mem_r[rl[p].a] & rl[p].m)
                    >> (s1_w_r[p] == EBK_W1 ? s1_addr_r[p][2:0] :
                        s1_w_r[p] == EBK_W2 ? {s1_addr_r[p][1:0], 1'b0} :
                        {s1_addr_r[p][0], 2'h0}));
            endcase
            // Writes and idle cycles leave the output untouched
            p2_vld_nxt[p] = s1_rd_r[p] && s1_oreg_r[p];
            p2_d_nxt[p] = p2_vld_nxt[p] ? rd_now[p] : p2_d_r[p];
            rv_nxt[p] = (s1_rd_r[p] && !s1_oreg_r[p]) || p2_vld_r[p];
            if (s1_rd_r[p] && !s1_oreg_r[p]) begin
                rd_nxt[p] = rd_now[p];
            end else if (p2_vld_r[p]) begin
                rd_nxt[p] = p2_d_r[p];
            end else begin
                rd_nxt[p] = rd_r[p];
            end
        end
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            s1_rd_r <= '0;
            s1_wr_r <= '0;
            s1_oreg_r <= '0;
            p2_vld_r <= '0;
            rv_r <= '0;
            s1_addr_r <= '{default: '0};
            s1_wd_r <= '{default: '0};
            s1_be_r <= '{default: '0};
            s1_w_r <= '{default: EBK_W9};
            p2_d_r <= '{default: '0};
            rd_r <= '{default: '0};
        end else begin
            s1_rd_r <= s1_rd_nxt;
            s1_wr_r <= s1_wr_nxt;
            s1_oreg_r <= s1_oreg_nxt;
            p2_vld_r <= p2_vld_nxt;
            rv_r <= rv_nxt;
            s1_addr_r <= s1_addr_nxt;
            s1_wd_r <= s1_wd_nxt;
            s1_be_r <= s1_be_nxt;
            s1_w_r <= s1_w_nxt;
            p2_d_r <= p2_d_nxt;
            rd_r <= rd_nxt;
        end
    end

    // Array has no reset; contents come only from init writes and port writes.
    // Port B is applied last, so it wins when both ports hit the same byte.
    always_ff @(posedge CLK_SYS) begin
        ebk_lane_t ln;
        if (init_we_r) begin
            mem_r[iaddr_r] <= idata_r;
        end
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < EBK_LANES; i++) begin
                ln = lane_f(s1_w_r[p], s1_addr_r[p], s1_wd_r[p], s1_be_r[p], 2'(i));
                if (s1_wr_r[p] && ln.on) begin
                    mem_r[ln.a] <= (mem_r[ln.a] & ~ln.m) | (ln.d & ln.m);
                end
            end
        end
    end

    // AXI4-Lite slave: address and data taken together, answer one cycle later
    assign wmask = {{8{S_AXI_WSTRB[3]}}, {8{S_AXI_WSTRB[2]}},
                    {8{S_AXI_WSTRB[1]}}, {8{S_AXI_WSTRB[0]}}};
    assign status = {24'h0, eff_w[1], eff_w[0], run, cfg_err};

    always_comb begin
        wst_nxt = wst_r;
        awready_nxt = 1'b0;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        ctrl_nxt = ctrl_r;
        iaddr_nxt = init_we_r ? iaddr_r + 11'h001 : iaddr_r;
        idata_nxt = idata_r;
        init_we_nxt = 1'b0;
        case (wst_r)
            EBK_AX_IDLE: begin
                if (S_AXI_AWVALID && S_AXI_WVALID) begin
                    awready_nxt = 1'b1;
                    wst_nxt = EBK_AX_ACK;
                end
            end
            EBK_AX_ACK: begin
                bvalid_nxt = 1'b1;
                bresp_nxt = EBK_RESP_OKAY;
                wst_nxt = EBK_AX_RESP;
                if (S_AXI_AWADDR == EBK_CTRL_OFS) begin
                    ctrl_nxt = (ctrl_r & ~wmask) | (S_AXI_WDATA & wmask);
                end else if (S_AXI_AWADDR == EBK_INIT_ADDR_OFS) begin
                    iaddr_nxt = S_AXI_WDATA[10:0];
                end else if (S_AXI_AWADDR == EBK_INIT_DATA_OFS) begin
                    // Preload only while stopped, so user ports never race it
                    idata_nxt = S_AXI_WDATA[8:0];
                    init_we_nxt = !run;
                end else if (S_AXI_AWADDR != EBK_STATUS_OFS) begin
                    bresp_nxt = EBK_RESP_SLVERR;
                end
            end
            EBK_AX_RESP: begin
                if (S_AXI_BREADY) begin
                    bvalid_nxt = 1'b0;
                    wst_nxt = EBK_AX_IDLE;
                end
            end
            default: wst_nxt = EBK_AX_IDLE;
        endcase
        rst_nxt = rst_r;
        arready_nxt = 1'b0;
        rvalid_nxt = rvalid_r;
        rresp_nxt = rresp_r;
        axrdata_nxt = axrdata_r;
        case (rst_r)
            EBK_AX_IDLE: begin
                if (S_AXI_ARVALID) begin
                    arready_nxt = 1'b1;
                    rst_nxt = EBK_AX_ACK;
                end
            end
            EBK_AX_ACK: begin
                rvalid_nxt = 1'b1;
                rresp_nxt = EBK_RESP_OKAY;
                axrdata_nxt = '0;
                rst_nxt = EBK_AX_RESP;
                if (S_AXI_ARADDR == EBK_CTRL_OFS) begin
                    axrdata_nxt = ctrl_r;
                end else if (S_AXI_ARADDR == EBK_INIT_ADDR_OFS) begin
                    axrdata_nxt = {21'h0, iaddr_r};
                end else if (S_AXI_ARADDR == EBK_INIT_DATA_OFS) begin
                    axrdata_nxt = {23'h0, idata_r};
                end else if (S_AXI_ARADDR == EBK_STATUS_OFS) begin
                    axrdata_nxt = status;
                end else begin
                    rresp_nxt = EBK_RESP_SLVERR;
                end
            end
            EBK_AX_RESP: begin
                if (S_AXI_RREADY) begin
                    rvalid_nxt = 1'b0;
                    rst_nxt = EBK_AX_IDLE;
                end
            end
            default: rst_nxt = EBK_AX_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            wst_r <= EBK_AX_IDLE;
            rst_r <= EBK_AX_IDLE;
            awready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= EBK_RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rresp_r <= EBK_RESP_OKAY;
            axrdata_r <= '0;
            ctrl_r <= EBK_CTRL_RST;
            iaddr_r <= EBK_INIT_ADDR_RST;
            idata_r <= '0;
            init_we_r <= 1'b0;
        end else begin
            wst_r <= wst_nxt;
            rst_r <= rst_nxt;
            awready_r <= awready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            axrdata_r <= axrdata_nxt;
            ctrl_r <= ctrl_nxt;
            iaddr_r <= iaddr_nxt;
            idata_r <= idata_nxt;
            init_we_r <= init_we_nxt;
        end
    end

    assign A_RDATA = rd_r[0];
    assign B_RDATA = rd_r[1];
    assign A_RVALID = rv_r[0];
    assign B_RVALID = rv_r[1];
    assign S_AXI_AWREADY = awready_r;
    assign S_AXI_WREADY = awready_r;
    assign S_AXI_BVALID = bvalid_r;
    assign S_AXI_BRESP = bresp_r;
    assign S_AXI_ARREADY = arready_r;
    assign S_AXI_RVALID = rvalid_r;
    assign S_AXI_RRESP = rresp_r;
    assign S_AXI_RDATA = axrdata_r;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RESET_N);

    in_capture_a: assert property (acc_wr[0] |=> s1_wr_r[0] && s1_addr_r[0] == $past(A_ADDR))
        else $error("port A write not captured in input registers");
    wr_hold_a: assert property (s1_wr_r[0] && !s1_rd_r[0] && !p2_vld_r[0]
                                |=> !A_RVALID && $stable(A_RDATA))
        else $error("write cycle disturbed port A output");
    bypass_lat_a: assert property (s1_rd_r[0] && !s1_oreg_r[0]
                                   |=> A_RVALID && A_RDATA == $past(rd_now[0]))
        else $error("bypassed read not valid one clock after registration");
    oreg_lat_a: assert property (s1_rd_r[0] && s1_oreg_r[0]
                                 ##1 !(s1_rd_r[0] && !s1_oreg_r[0])
                                 |=> A_RVALID && A_RDATA == $past(rd_now[0], 2))
        else $error("registered read not valid two clocks after registration");
    byte_mask_a: assert property (s1_wr_r[0] && !s1_wr_r[1] && s1_w_r[0] == EBK_W36
                                  && !s1_be_r[0][1] && !init_we_r
                                  |=> mem_r[{$past(s1_addr_r[0][8:0]), 2'h1}]
                                      == $past(mem_r[{s1_addr_r[0][8:0], 2'h1}]))
        else $error("disabled byte lane was written");
    bit_order_a: assert property (s1_wr_r[0] && !s1_wr_r[1] && s1_w_r[0] == EBK_W1
                                  |=> mem_r[$past(s1_addr_r[0][13:3])][$past(s1_addr_r[0][2:0])]
                                      == $past(s1_wd_r[0][0]))
        else $error("single bit write landed in the wrong place");
    parity_a: assert property (s1_wr_r[1] && s1_w_r[1] == EBK_W9
                               |=> mem_r[$past(s1_addr_r[1][10:0])] == $past(s1_wd_r[1][8:0]))
        else $error("nine bit byte with parity not stored");
    tdp_width_a: assert property (mode_eff == EBK_TDP |-> eff_w[0] != EBK_W36
                                  && eff_w[1] != EBK_W36)
        else $error("36 bit width offered in true dual port mode");
    pdp_dir_a: assert property (mode_eff == EBK_PDP |-> !acc_rd[0] && !acc_wr[1])
        else $error("pseudo dual port direction violated");
    init_gate_a: assert property (!run |=> s1_rd_r == 2'h0 && s1_wr_r == 2'h0)
        else $error("user port access while stopped");

    read_bypass_c: cover property (s1_rd_r[0] && !s1_oreg_r[0] ##1 A_RVALID);
    read_oreg_c: cover property (s1_rd_r[0] && s1_oreg_r[0] ##2 A_RVALID);
    preload_c: cover property (init_we_r ##[1:20] run);
    tdp_both_c: cover property (mode_eff == EBK_TDP && s1_wr_r == 2'h3);
endmodule : ebk_block_ram

// ---- verification/ebk_fabric_model.sv ----
/*
 * Fabric user logic model that drives both RAM ports, index 0 port A, 1 port B.
 * Assumes it shares the RAM clock and that callers enter acc just after an edge.
 */
`timescale 1ns/1ps
module ebk_fabric_model (
    // Clock
    input wire logic clk,
    // Requests
    output logic [1:0] en,
    output logic [1:0] we,
    output logic [1:0][13:0] addr,
    output logic [1:0][35:0] wd,
    output logic [1:0][3:0] be,
    // Answers
    input wire logic [1:0][35:0] rd,
    input wire logic [1:0] rv
);
    // Write controls idle low, so a preloaded array behaves as ROM
    initial begin
        en = '0;
        we = '0;
        addr = '0;
        wd = '0;
        be = '0;
    end

    // One access; lat is the edge count from capture to valid data, 0 if none
    task automatic acc(input int p, input logic w, input logic [13:0] a, input logic [35:0] d,
                       input logic [3:0] b, output logic [35:0] q, output int lat);
        lat = 0;
        en[p] <= 1'b1;
        we[p] <= w;
        addr[p] <= a;
        wd[p] <= d;
        be[p] <= b;
        @(posedge clk);
        en[p] <= 1'b0;
        we[p] <= 1'b0;
        // Released address and data lines show the inverse, so stale values are never trusted
        addr[p] <= ~a;
        wd[p] <= ~d;
        for (int n = 1; n < 5 && lat == 0; n++) begin
            @(posedge clk);
            if (rv[p] === 1'b1) begin
                lat = n;
            end
        end
        q = rd[p];
    endtask : acc
endmodule : ebk_fabric_model

// ---- verification/tb_top.sv ----
/*
 * Self-checking bench: AXI4-Lite register tasks plus fabric port accesses.
 * Assumes the design package and the fabric model are compiled first.
 */
`timescale 1ns/1ps
module tb_top;
    import ebk_pkg::*;
    logic clk_sys, reset_n, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, en, we, rv;
    logic [1:0][13:0] addr;
    logic [1:0][35:0] wd, rd;
    logic [1:0][3:0] be;
    logic [8:0] pre [4] = '{9'h1A5, 9'h0F0, 9'h133, 9'h0CC};
    int n_fail = 0;
    int total_checks = 0;

    ebk_block_ram ebk_block_ram_i (.CLK_SYS(clk_sys), .RESET_N(reset_n),
        .A_EN(en[0]), .A_WE(we[0]), .A_ADDR(addr[0]), .A_WDATA(wd[0]), .A_BE(be[0]),
        .A_RDATA(rd[0]), .A_RVALID(rv[0]),
        .B_EN(en[1]), .B_WE(we[1]), .B_ADDR(addr[1]), .B_WDATA(wd[1]), .B_BE(be[1]),
        .B_RDATA(rd[1]), .B_RVALID(rv[1]),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
        .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
        .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
        .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
        .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    ebk_fabric_model ebk_fabric_model_i (.clk(clk_sys), .en(en), .we(we), .addr(addr),
        .wd(wd), .be(be), .rd(rd), .rv(rv));

    task automatic chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", 36'(bresp), 36'(er));
        @(posedge clk_sys);
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge clk_sys);
    endtask : axi_rd

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    // Whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_fail++;
        conclude();
    end

    initial begin
        logic [31:0] v;
        logic [1:0] r;
        logic [35:0] q;
        int lat;
        reset_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        wstrb = 4'hF;
        repeat (3) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        axi_rd(EBK_CTRL_OFS, v, r);
        chk("ctrl reset", 36'(v), 36'(EBK_CTRL_RST));
        axi_rd(8'h10, v, r);
        chk("unmapped rresp", 36'(r), 36'(EBK_RESP_SLVERR));
        axi_wr(8'h14, 32'h0, EBK_RESP_SLVERR);
        ebk_fabric_model_i.acc(0, 1'b0, 14'h0, 36'h0, 4'h0, q, lat);
        chk("stopped port", 36'(lat), 36'h0);
        $display("test reset done");
        axi_wr(EBK_INIT_ADDR_OFS, 32'h0, EBK_RESP_OKAY);
        foreach (pre[i]) axi_wr(EBK_INIT_DATA_OFS, 32'(pre[i]), EBK_RESP_OKAY);
        axi_wr(EBK_CTRL_OFS, 32'h0000_00E9, EBK_RESP_OKAY);
        ebk_fabric_model_i.acc(0, 1'b0, 14'h0, 36'h0, 4'h0, q, lat);
        chk("x36 read", q, {pre[3], pre[2], pre[1], pre[0]});
        chk("bypass latency", 36'(lat), 36'h2);
        ebk_fabric_model_i.acc(0, 1'b1, 14'h0, {36{1'b1}}, 4'h5, q, lat);
        chk("write no valid", 36'(lat), 36'h0);
        chk("write output", q, {pre[3], pre[2], pre[1], pre[0]});
        ebk_fabric_model_i.acc(0, 1'b0, 14'h0, 36'h0, 4'h0, q, lat);
        chk("byte enables", q, {pre[3], 9'h1FF, pre[1], 9'h1FF});
        $display("test x36 done");
        axi_wr(EBK_CTRL_OFS, 32'h0000_00C1, EBK_RESP_OKAY);
        for (int k = 0; k < 8; k++) begin
            ebk_fabric_model_i.acc(0, 1'b0, 14'(8 + k), 36'h0, 4'h0, q, lat);
            chk("x1 bit", 36'(q[0]), 36'(pre[1][k]));
        end
        ebk_fabric_model_i.acc(0, 1'b1, 14'h25, 36'h1, 4'h0, q, lat);
        ebk_fabric_model_i.acc(0, 1'b0, 14'h25, 36'h0, 4'h0, q, lat);
        chk("x1 write", 36'(q[0]), 36'h1);
        axi_wr(EBK_CTRL_OFS, 32'h0000_02E9, EBK_RESP_OKAY);
        ebk_fabric_model_i.acc(0, 1'b0, 14'h0, 36'h0, 4'h0, q, lat);
        chk("out reg latency", 36'(lat), 36'h3);
        chk("out reg data", q, {pre[3], 9'h1FF, pre[1], 9'h1FF});
        $display("test widths done");
        axi_wr(EBK_CTRL_OFS, 32'h0000_00EB, EBK_RESP_OKAY);
        axi_rd(EBK_STATUS_OFS, v, r);
        chk("tdp clamp", 36'(v), 36'h73);
        ebk_fabric_model_i.acc(1, 1'b1, 14'h3, 36'h055, 4'h0, q, lat);
        ebk_fabric_model_i.acc(1, 1'b0, 14'h1, 36'h0, 4'h0, q, lat);
        chk("port b x9", 36'(q[8:0]), 36'(pre[1]));
        chk("port b latency", 36'(lat), 36'h2);
        ebk_fabric_model_i.acc(0, 1'b0, 14'h1, 36'h0, 4'h0, q, lat);
        chk("port a x18", 36'(q[17:0]), {18'h0, 9'h055, 9'h1FF});
        axi_wr(EBK_CTRL_OFS, 32'h0000_00ED, EBK_RESP_OKAY);
        ebk_fabric_model_i.acc(0, 1'b0, 14'h0, 36'h0, 4'h0, q, lat);
        chk("pdp port a read", 36'(lat), 36'h0);
        ebk_fabric_model_i.acc(1, 1'b1, 14'h3, 36'h0AA, 4'h0, q, lat);
        ebk_fabric_model_i.acc(1, 1'b0, 14'h3, 36'h0, 4'h0, q, lat);
        chk("pdp port b write", 36'(q[8:0]), 36'h055);
        chk("pdp port b latency", 36'(lat), 36'h2);
        $display("test dual done");
        conclude();
    end
endmodule : tb_top
